// ==== rtl/dalu_pkg.sv ====
// Shared constants and types for the data arithmetic unit.
// Assumes a single core clock and an instruction decoder on the same clock.
`default_nettype none
package dalu_pkg;
  localparam int DW = 24;
  localparam int EW = 8;
  localparam int AW = 56;
  localparam int SHW = 6;
  localparam int SELW = 2;

  // Arithmetic operations issued by the decoder.
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CLR = 4'h1,
    OP_MPY = 4'h2,
    OP_MAC = 4'h3,
    OP_ADD = 4'h4,
    OP_SUB = 4'h5,
    OP_TFR = 4'h6,
    OP_ASL = 4'h7,
    OP_ASR = 4'h8,
    OP_LSR = 4'h9,
    OP_NORM = 4'ha
  } dalu_op_e;

  // Bus-addressable registers; FULL codes move a whole accumulator.
  typedef enum logic [3:0] {
    RS_XL = 4'h0,
    RS_XH = 4'h1,
    RS_YL = 4'h2,
    RS_YH = 4'h3,
    RS_AE = 4'h4,
    RS_AH = 4'h5,
    RS_AL = 4'h6,
    RS_AF = 4'h7,
    RS_BE = 4'h8,
    RS_BH = 4'h9,
    RS_BL = 4'ha,
    RS_BF = 4'hb
  } dalu_reg_e;

  // Second operand of add, subtract and transfer.
  typedef enum logic [2:0] {
    SRC_XL = 3'h0,
    SRC_XH = 3'h1,
    SRC_YL = 3'h2,
    SRC_YH = 3'h3,
    SRC_XP = 3'h4,
    SRC_YP = 3'h5,
    SRC_ACC = 3'h6
  } dalu_src_e;

  // Multiplier operand signedness.
  typedef enum logic [1:0] {
    SG_SS = 2'h0,
    SG_SU = 2'h1,
    SG_UU = 2'h2
  } dalu_sgn_e;

  localparam logic [AW-1:0] RND_HALF = 56'h00_0000_0080_0000;
  localparam logic [AW-1:0] LOW_MASK = 56'h00_0000_00ff_ffff;
  localparam logic [DW-1:0] M16_MASK = 24'hff_ff00;
  localparam logic [DW-1:0] LIM_POS = 24'h7f_ffff;
  localparam logic [DW-1:0] LIM_NEG = 24'h80_0000;
  localparam logic [DW-1:0] WORD_ZERO = 24'h00_0000;
  localparam logic [EW-1:0] PAD16 = 8'h00;
  localparam logic [SHW-1:0] SH_ONE = 6'h01;
endpackage
`default_nettype wire

// ==== rtl/dalu_lim_if.sv ====
// Carrier between the arithmetic core and one bus shifter/limiter.
// Assumes the core drives the accumulator value combinationally.
`timescale 1ns/1ps
`default_nettype none
interface dalu_lim_if;
  import dalu_pkg::*;
  logic [AW-1:0] acc;
  logic [DW-1:0] word;
  logic lim;
  modport lim_side (input acc, output word, output lim);
  modport core_side (output acc, input word, input lim);
endinterface
`default_nettype wire

// ==== rtl/dalu_limiter.sv ====
// Data bus limiter: squeezes a 56-bit accumulator into one 24-bit word.
// Assumes the caller registers the word before it leaves the block.
`timescale 1ns/1ps
`default_nettype none
module dalu_limiter
  import dalu_pkg::*;
(
  dalu_lim_if.lim_side lp
);
  // The word fits when extension and the high sign bit all agree.
  wire logic [EW:0] top_bits = lp.acc[AW-1:AW-EW-1];
  wire logic fits = (&top_bits) | (~|top_bits);

  // Saturate rather than wrap, so a stored value keeps its sign.
  assign lp.word = fits ? lp.acc[2*DW-1:DW] : (lp.acc[AW-1] ? LIM_NEG : LIM_POS);
  assign lp.lim = ~fits;
endmodule
`default_nettype wire

// ==== rtl/dalu_core.sv ====
// Data arithmetic unit: input registers, two accumulators, multiplier-accumulator, barrel shifter.
// Assumes decoder and X/Y bus controls come from logic on core_clk.
// How it works
// - Each operation spans two pipelined cycles; a new one may start every cycle.
// - A result is usable by the very next operation without any stall.
// - Arithmetic results land only in an accumulator.
// - Operands come only from unit registers, 16, 32 or 24 bits (extension plus upper 16) in 16-bit mode.
// - 24x24 fractional multiply, signed, unsigned or mixed, fully pipelined.
// - The 48-bit product is right-justified and added to the chosen accumulator.
// - Up to three operands give one result of extension, upper and lower fields.
// - An accumulator can be stored out as one 24-bit word.
// - The lower field is truncated, or rounded into the upper one on request.
// - Each accumulator is three separately addressable parts.
// - Four input registers, used alone as 24 bits or paired as 48 bits.
// - Registers move over the X and Y buses, 24-bit transfers, or 16-bit in 16-bit mode.
// - Software picks 24, 48 or 56-bit arithmetic precision.
// - A 56-bit barrel shifter does shifts and normalization.
// - Each bus output has its own shifter/limiter from the accumulators.
`timescale 1ns/1ps
`default_nettype none
module dalu_core
  import dalu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire dalu_op_e op_code,
  input wire logic op_acc,
  input wire logic [SELW-1:0] op_mul_a,
  input wire logic [SELW-1:0] op_mul_b,
  input wire dalu_src_e op_src,
  input wire dalu_sgn_e op_sgn,
  input wire logic op_neg,
  input wire logic op_rnd,
  input wire logic [SHW-1:0] op_shamt,
  input wire logic mode16,
  input wire logic x_wr_en,
  input wire dalu_reg_e x_wr_sel,
  input wire logic [DW-1:0] x_wr_data,
  input wire logic y_wr_en,
  input wire dalu_reg_e y_wr_sel,
  input wire logic [DW-1:0] y_wr_data,
  input wire logic x_rd_en,
  input wire dalu_reg_e x_rd_sel,
  input wire logic y_rd_en,
  input wire dalu_reg_e y_rd_sel,
  output logic [DW-1:0] x_rd_data,
  output logic x_rd_valid,
  output logic x_rd_lim,
  output logic [DW-1:0] y_rd_data,
  output logic y_rd_valid,
  output logic y_rd_lim,
  output logic alu_done,
  output logic alu_done_acc
);
  logic [DW-1:0] input_reg_x_high_r, input_reg_x_low_r, input_reg_y_high_r, input_reg_y_low_r;
  logic [AW-1:0] acc_first_r, acc_second_r, acc_first_nxt, acc_second_nxt;
  logic s1_valid_r, s1_acc_r, s1_rnd_r, s1_use_acc_r;
  dalu_op_e s1_op_r;
  logic [AW-1:0] s1_prod_r, s1_opnd_r;
  logic [SHW-1:0] s1_shamt_r;
  logic [DW-1:0] x_rd_data_r, y_rd_data_r;
  logic x_rd_valid_r, x_rd_lim_r, y_rd_valid_r, y_rd_lim_r, alu_done_r, alu_done_acc_r;
  logic [AW-1:0] res, res_fin;

  // Named part views of the accumulators.
  wire logic [EW-1:0] acc_first_extension = acc_first_r[AW-1:2*DW];
  wire logic [DW-1:0] acc_first_high = acc_first_r[2*DW-1:DW];
  wire logic [DW-1:0] acc_first_low = acc_first_r[DW-1:0];
  wire logic [EW-1:0] acc_second_extension = acc_second_r[AW-1:2*DW];
  wire logic [DW-1:0] acc_second_high = acc_second_r[2*DW-1:DW];
  wire logic [DW-1:0] acc_second_low = acc_second_r[DW-1:0];

  // Redundant sign bits below the top; stops one bit short so zero stays put.
  function automatic logic [SHW-1:0] dalu_nrm(input logic [AW-1:0] v);
    logic [SHW-1:0] n;
    logic go;
    n = '0;
    go = 1'b1;
    for (int i = AW - 2; i > 0; i--) begin
      if (go && (v[i] == v[AW-1])) begin
        n = n + SH_ONE;
      end else begin
        go = 1'b0;
      end
    end
    return n;
  endfunction

  // Bus write of one part or a whole accumulator.
  function automatic logic [AW-1:0] dalu_acc_wr(input logic [AW-1:0] cur, input logic [1:0] part,
                                                input logic [DW-1:0] d);
    logic [AW-1:0] v;
    v = cur;
    case (part)
      2'h0: v[AW-1:2*DW] = d[EW-1:0];
      2'h1: v[2*DW-1:DW] = d;
      2'h2: v[DW-1:0] = d;
      default: v = {{EW{d[DW-1]}}, d, WORD_ZERO};
    endcase
    return v;
  endfunction

  // In 16-bit mode bus words sit in the upper 16 bits of a register.
  wire logic [DW-1:0] x_word = mode16 ? {x_wr_data[DW-EW-1:0], PAD16} : x_wr_data;
  wire logic [DW-1:0] y_word = mode16 ? {y_wr_data[DW-EW-1:0], PAD16} : y_wr_data;
  wire logic [DW-1:0] w_mask = mode16 ? M16_MASK : ~WORD_ZERO;

  // Input register writes come only from the buses; X wins a same-register clash.
  wire logic wx_xh = x_wr_en && (x_wr_sel == RS_XH);
  wire logic wx_xl = x_wr_en && (x_wr_sel == RS_XL);
  wire logic wx_yh = x_wr_en && (x_wr_sel == RS_YH);
  wire logic wx_yl = x_wr_en && (x_wr_sel == RS_YL);
  wire logic wy_xh = y_wr_en && (y_wr_sel == RS_XH);
  wire logic wy_xl = y_wr_en && (y_wr_sel == RS_XL);
  wire logic wy_yh = y_wr_en && (y_wr_sel == RS_YH);
  wire logic wy_yl = y_wr_en && (y_wr_sel == RS_YL);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      input_reg_x_high_r <= WORD_ZERO;
      input_reg_x_low_r <= WORD_ZERO;
      input_reg_y_high_r <= WORD_ZERO;
      input_reg_y_low_r <= WORD_ZERO;
    end else begin
      input_reg_x_high_r <= wx_xh ? x_word : (wy_xh ? y_word : input_reg_x_high_r);
      input_reg_x_low_r <= wx_xl ? x_word : (wy_xl ? y_word : input_reg_x_low_r);
      input_reg_y_high_r <= wx_yh ? x_word : (wy_yh ? y_word : input_reg_y_high_r);
      input_reg_y_low_r <= wx_yl ? x_word : (wy_yl ? y_word : input_reg_y_low_r);
    end
  end

  // Stage one: operand fetch from unit registers only, masked in 16-bit mode.
  wire logic [DW-1:0] in_w [4];
  assign in_w[0] = input_reg_x_low_r & w_mask;
  assign in_w[1] = input_reg_x_high_r & w_mask;
  assign in_w[2] = input_reg_y_low_r & w_mask;
  assign in_w[3] = input_reg_y_high_r & w_mask;
  wire logic [DW-1:0] mul_a = in_w[op_mul_a];
  wire logic [DW-1:0] mul_b = in_w[op_mul_b];

  // Fractional multiply: 25-bit extension picks signed or unsigned per operand.
  wire logic sa = (op_sgn != SG_UU);
  wire logic sb = (op_sgn == SG_SS);
  wire logic signed [DW:0] m1 = {sa & mul_a[DW-1], mul_a};
  wire logic signed [DW:0] m2 = {sb & mul_b[DW-1], mul_b};
  wire logic signed [2*DW+1:0] mprod = m1 * m2;
  wire logic [AW-1:0] frac = {{(AW-2*DW-2){mprod[2*DW+1]}}, mprod[2*DW:0], 1'b0};
  wire logic [AW-1:0] prod_s = op_neg ? (~frac + 56'h00_0000_0000_0001) : frac;

  // Precision: single word is 24-bit, a pair is 48-bit, the other accumulator 56-bit.
  wire logic [DW-1:0] src_w = in_w[op_src[1:0]];
  wire logic [AW-1:0] opnd_single = {{EW{src_w[DW-1]}}, src_w, WORD_ZERO};
  wire logic [AW-1:0] opnd_x_pair = {{EW{in_w[1][DW-1]}}, in_w[1], in_w[0]};
  wire logic [AW-1:0] opnd_y_pair = {{EW{in_w[3][DW-1]}}, in_w[3], in_w[2]};
  wire logic [AW-1:0] opnd_sel = (op_src == SRC_XP) ? opnd_x_pair :
                                 (op_src == SRC_YP) ? opnd_y_pair : opnd_single;

  // Pipeline register between the two stages.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_valid_r <= 1'b0;
      s1_op_r <= OP_NOP;
      s1_acc_r <= 1'b0;
      s1_rnd_r <= 1'b0;
      s1_use_acc_r <= 1'b0;
      s1_prod_r <= '0;
      s1_opnd_r <= '0;
      s1_shamt_r <= '0;
    end else begin
      s1_valid_r <= op_valid;
      s1_op_r <= op_valid ? op_code : OP_NOP;
      s1_acc_r <= op_acc;
      s1_rnd_r <= op_rnd;
      s1_use_acc_r <= (op_src == SRC_ACC);
      s1_prod_r <= prod_s;
      s1_opnd_r <= opnd_sel;
      s1_shamt_r <= op_shamt;
    end
  end

  // Stage two reads the accumulators as they stand now, so a result written last
  // cycle feeds this operation directly and no interlock is needed.
  wire logic [AW-1:0] acc_cur = s1_acc_r ? acc_second_r : acc_first_r;
  wire logic [AW-1:0] acc_oth = s1_acc_r ? acc_first_r : acc_second_r;
  wire logic [AW-1:0] oth_m = mode16 ? {acc_oth[AW-1:2*DW], w_mask & acc_oth[2*DW-1:DW], WORD_ZERO} : acc_oth;
  wire logic [AW-1:0] addend = s1_use_acc_r ? oth_m : s1_opnd_r;
  wire logic [SHW-1:0] nrm_cnt = dalu_nrm(acc_cur);

  // Arithmetic and barrel shifter: three operands in, one 56-bit result out.
  always_comb begin
    res = acc_cur;
    case (s1_op_r)
      OP_CLR: res = '0;
      OP_MPY: res = s1_prod_r;
      OP_MAC: res = acc_cur + s1_prod_r;
      OP_ADD: res = acc_cur + addend;
      OP_SUB: res = acc_cur - addend;
      OP_TFR: res = addend;
      OP_ASL: res = acc_cur << s1_shamt_r;
      OP_ASR: res = $signed(acc_cur) >>> s1_shamt_r;
      OP_LSR: res = acc_cur >> s1_shamt_r;
      OP_NORM: res = acc_cur << nrm_cnt;
      default: res = acc_cur;
    endcase
  end

  // Rounding adds half an upper-field unit and clears the lower field.
  assign res_fin = s1_rnd_r ? ((res + RND_HALF) & ~LOW_MASK) : res;
  wire logic wr_first = s1_valid_r && (s1_op_r != OP_NOP) && !s1_acc_r;
  wire logic wr_second = s1_valid_r && (s1_op_r != OP_NOP) && s1_acc_r;

  // Bus part writes; the arithmetic result takes priority in the same cycle.
  wire logic bx_a = x_wr_en && (x_wr_sel >= RS_AE) && (x_wr_sel <= RS_AF);
  wire logic by_a = y_wr_en && (y_wr_sel >= RS_AE) && (y_wr_sel <= RS_AF);
  wire logic bx_b = x_wr_en && (x_wr_sel >= RS_BE) && (x_wr_sel <= RS_BF);
  wire logic by_b = y_wr_en && (y_wr_sel >= RS_BE) && (y_wr_sel <= RS_BF);
  wire logic [1:0] px = x_wr_sel[1:0] - 2'h0;
  wire logic [1:0] py = y_wr_sel[1:0] - 2'h0;
  wire logic [1:0] pxb = x_wr_sel[1:0];
  wire logic [1:0] pyb = y_wr_sel[1:0];

  always_comb begin
    acc_first_nxt = acc_first_r;
    acc_second_nxt = acc_second_r;
    if (by_a) acc_first_nxt = dalu_acc_wr(acc_first_nxt, py, y_word);
    if (bx_a) acc_first_nxt = dalu_acc_wr(acc_first_nxt, px, x_word);
    if (by_b) acc_second_nxt = dalu_acc_wr(acc_second_nxt, pyb, y_word);
    if (bx_b) acc_second_nxt = dalu_acc_wr(acc_second_nxt, pxb, x_word);
    if (wr_first) acc_first_nxt = res_fin;
    if (wr_second) acc_second_nxt = res_fin;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_first_r <= '0;
      acc_second_r <= '0;
      alu_done_r <= 1'b0;
      alu_done_acc_r <= 1'b0;
    end else begin
      acc_first_r <= acc_first_nxt;
      acc_second_r <= acc_second_nxt;
      alu_done_r <= s1_valid_r;
      alu_done_acc_r <= s1_acc_r;
    end
  end

  // One limiter per bus output, fed by whichever accumulator is being read.
  dalu_lim_if lim_x ();
  dalu_lim_if lim_y ();
  assign lim_x.acc = (x_rd_sel == RS_BF) ? acc_second_r : acc_first_r;
  assign lim_y.acc = (y_rd_sel == RS_BF) ? acc_second_r : acc_first_r;
  dalu_limiter u_lim_x (.lp(lim_x.lim_side));
  dalu_limiter u_lim_y (.lp(lim_y.lim_side));

  // Raw register view for part reads; extension reads sign-extended.
  function automatic logic [DW-1:0] dalu_raw(input dalu_reg_e s, input logic [DW-1:0] xh, xl, yh, yl,
                                             input logic [AW-1:0] a, b);
    logic [DW-1:0] v;
    v = WORD_ZERO;
    if (s == RS_XL) v = xl;
    else if (s == RS_XH) v = xh;
    else if (s == RS_YL) v = yl;
    else if (s == RS_YH) v = yh;
    else if (s == RS_AE) v = {{(DW-EW){a[AW-1]}}, a[AW-1:2*DW]};
    else if (s == RS_AH) v = a[2*DW-1:DW];
    else if (s == RS_AL) v = a[DW-1:0];
    else if (s == RS_BE) v = {{(DW-EW){b[AW-1]}}, b[AW-1:2*DW]};
    else if (s == RS_BH) v = b[2*DW-1:DW];
    else if (s == RS_BL) v = b[DW-1:0];
    return v;
  endfunction

  wire logic x_full = (x_rd_sel == RS_AF) || (x_rd_sel == RS_BF);
  wire logic y_full = (y_rd_sel == RS_AF) || (y_rd_sel == RS_BF);
  wire logic [DW-1:0] x_raw = dalu_raw(x_rd_sel, input_reg_x_high_r, input_reg_x_low_r,
                                       input_reg_y_high_r, input_reg_y_low_r, acc_first_r, acc_second_r);
  wire logic [DW-1:0] y_raw = dalu_raw(y_rd_sel, input_reg_x_high_r, input_reg_x_low_r,
                                       input_reg_y_high_r, input_reg_y_low_r, acc_first_r, acc_second_r);
  wire logic [DW-1:0] x_pick = x_full ? lim_x.word : x_raw;
  wire logic [DW-1:0] y_pick = y_full ? lim_y.word : y_raw;
  wire logic [DW-1:0] x_out = mode16 ? {PAD16, x_pick[DW-1:EW]} : x_pick;
  wire logic [DW-1:0] y_out = mode16 ? {PAD16, y_pick[DW-1:EW]} : y_pick;

  // Read data is held until the next read on that bus.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      x_rd_data_r <= WORD_ZERO;
      x_rd_valid_r <= 1'b0;
      x_rd_lim_r <= 1'b0;
      y_rd_data_r <= WORD_ZERO;
      y_rd_valid_r <= 1'b0;
      y_rd_lim_r <= 1'b0;
    end else begin
      x_rd_valid_r <= x_rd_en;
      y_rd_valid_r <= y_rd_en;
      if (x_rd_en) x_rd_data_r <= x_out;
      if (x_rd_en) x_rd_lim_r <= x_full && lim_x.lim;
      if (y_rd_en) y_rd_data_r <= y_out;
      if (y_rd_en) y_rd_lim_r <= y_full && lim_y.lim;
    end
  end

  assign x_rd_data = x_rd_data_r;
  assign x_rd_valid = x_rd_valid_r;
  assign x_rd_lim = x_rd_lim_r;
  assign y_rd_data = y_rd_data_r;
  assign y_rd_valid = y_rd_valid_r;
  assign y_rd_lim = y_rd_lim_r;
  assign alu_done = alu_done_r;
  assign alu_done_acc = alu_done_acc_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_PIPE: assert property (op_valid |-> ##2 alu_done)
    else $error("operation did not finish two cycles after issue");
  AST_FWD: assert property (s1_valid_r && s1_op_r == OP_MAC && !s1_acc_r && !s1_rnd_r
    |=> acc_first_r == $past(56'(acc_first_r + s1_prod_r)))
    else $error("accumulate did not use the current accumulator");
  AST_IN_ONLY_BUS: assert property (!x_wr_en && !y_wr_en |=> $stable(input_reg_x_high_r)
    && $stable(input_reg_x_low_r) && $stable(input_reg_y_high_r) && $stable(input_reg_y_low_r))
    else $error("input register changed without a bus write");
  AST_MPY: assert property (op_valid && op_code == OP_MPY && !op_acc && !op_rnd
    |-> ##2 acc_first_r == $past(prod_s, 2))
    else $error("multiply result wrong");
  AST_RND: assert property (s1_valid_r && s1_rnd_r && !s1_acc_r && s1_op_r != OP_NOP
    |=> acc_first_low == WORD_ZERO)
    else $error("rounded result kept a lower field");
  AST_ASR: assert property (s1_valid_r && s1_op_r == OP_ASR && s1_acc_r && !s1_rnd_r
    |=> acc_second_r == $past(56'($signed(acc_second_r) >>> s1_shamt_r)))
    else $error("arithmetic shift wrong");
  AST_PART: assert property (x_wr_en && x_wr_sel == RS_AH && !mode16 && !wr_first
    |=> acc_first_high == $past(x_wr_data) && acc_first_low == $past(acc_first_low))
    else $error("high part write wrong");
  AST_RD_FIT: assert property (x_rd_en && x_rd_sel == RS_AF && !mode16
    && ((&acc_first_r[AW-1:2*DW-1]) || !(|acc_first_r[AW-1:2*DW-1]))
    |=> x_rd_valid && x_rd_data == $past(acc_first_high) && !x_rd_lim)
    else $error("fitting accumulator read wrong");
  AST_LIM: assert property (y_rd_en && y_rd_sel == RS_AF && !mode16 && !acc_first_r[AW-1]
    && (|acc_first_r[AW-2:2*DW-1]) |=> y_rd_data == LIM_POS && y_rd_lim)
    else $error("positive overflow did not saturate");
endmodule
`default_nettype wire

// ==== verification/dalu_dec_model.sv ====
// Model of the instruction decoder and the X/Y data buses that feed the arithmetic unit.
// Assumes every task is called at a falling edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module dalu_dec_model
  import dalu_pkg::*;
(
  input wire logic core_clk,
  output logic op_valid,
  output dalu_op_e op_code,
  output logic op_acc,
  output logic [SELW-1:0] op_mul_a,
  output logic [SELW-1:0] op_mul_b,
  output dalu_src_e op_src,
  output dalu_sgn_e op_sgn,
  output logic op_rnd,
  output logic [SHW-1:0] op_shamt,
  output logic mode16,
  output logic [1:0] wr_en,
  output dalu_reg_e wr_sel,
  output logic [DW-1:0] wr_data,
  output logic [1:0] rd_en,
  output dalu_reg_e rd_sel
);
  // Everything idles at time zero so the unit never sees an unknown control.
  initial begin
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_acc = 1'b0;
    op_mul_a = 2'h0;
    op_mul_b = 2'h0;
    op_src = SRC_XL;
    op_sgn = SG_SS;
    op_rnd = 1'b0;
    op_shamt = 6'h00;
    mode16 = 1'b0;
    wr_en = 2'h0;
    wr_sel = RS_XL;
    wr_data = 24'h00_0000;
    rd_en = 2'h0;
    rd_sel = RS_XL;
  end

  // Valid is left high so that two issues can follow back to back; idle lowers it.
  task automatic issue(input dalu_op_e op, input logic acc, input logic [1:0] ma, input logic [1:0] mb,
                       input dalu_src_e src, input dalu_sgn_e sg, input logic rnd, input logic [SHW-1:0] sh);
    op_valid = 1'b1;
    op_code = op;
    op_acc = acc;
    op_mul_a = ma;
    op_mul_b = mb;
    op_src = src;
    op_sgn = sg;
    op_rnd = rnd;
    op_shamt = sh;
    @(negedge core_clk);
  endtask

  task automatic idle();
    op_valid = 1'b0;
  endtask

  task automatic set16(input logic m);
    mode16 = m;
  endtask

  // A released data line shows the inverse of its last word, never a stale copy.
  task automatic wr(input logic bus, input dalu_reg_e sel, input logic [DW-1:0] d);
    wr_en[bus] = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 2'h0;
    wr_data = ~d;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic bus, input dalu_reg_e sel);
    rd_en[bus] = 1'b1;
    rd_sel = sel;
    @(negedge core_clk);
    rd_en = 2'h0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the data arithmetic unit, driven through the decoder model.
// Assumes the model moves all controls at the falling clock edge, one cycle per request and two per write.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dalu_pkg::*;
  logic core_clk;
  logic rst_n;
  logic op_valid, op_acc, op_rnd, mode16;
  dalu_op_e op_code;
  dalu_src_e op_src;
  dalu_sgn_e op_sgn;
  dalu_reg_e wr_sel, rd_sel;
  logic [SELW-1:0] op_mul_a, op_mul_b;
  logic [SHW-1:0] op_shamt;
  logic [1:0] wr_en, rd_en;
  logic [DW-1:0] wr_data, x_rd_data, y_rd_data;
  logic x_rd_valid, x_rd_lim, y_rd_valid, y_rd_lim, alu_done, alu_done_acc;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic op_neg = 1'b0;

  // Negation is driven by the bench itself; the decoder model has no field for it.
  dalu_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_acc(op_acc), .op_mul_a(op_mul_a), .op_mul_b(op_mul_b), .op_src(op_src), .op_sgn(op_sgn),
    .op_neg(op_neg), .op_rnd(op_rnd), .op_shamt(op_shamt), .mode16(mode16), .x_wr_en(wr_en[0]),
    .x_wr_sel(wr_sel), .x_wr_data(wr_data), .y_wr_en(wr_en[1]), .y_wr_sel(wr_sel), .y_wr_data(wr_data),
    .x_rd_en(rd_en[0]), .x_rd_sel(rd_sel), .y_rd_en(rd_en[1]), .y_rd_sel(rd_sel), .x_rd_data(x_rd_data),
    .x_rd_valid(x_rd_valid), .x_rd_lim(x_rd_lim), .y_rd_data(y_rd_data), .y_rd_valid(y_rd_valid),
    .y_rd_lim(y_rd_lim), .alu_done(alu_done), .alu_done_acc(alu_done_acc));

  dalu_dec_model p_u (.core_clk(core_clk), .op_valid(op_valid), .op_code(op_code), .op_acc(op_acc),
    .op_mul_a(op_mul_a), .op_mul_b(op_mul_b), .op_src(op_src), .op_sgn(op_sgn), .op_rnd(op_rnd),
    .op_shamt(op_shamt), .mode16(mode16), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .rd_en(rd_en), .rd_sel(rd_sel));

  // Clock of 4 ns period.
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  // The whole run needs well under a thousand cycles, so this ceiling only cuts a hang.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic bus, input dalu_reg_e sel, input logic [DW-1:0] exp);
    p_u.rd(bus, sel);
    chk(DW'(bus ? y_rd_valid : x_rd_valid), 24'h00_0001);
    chk(bus ? y_rd_data : x_rd_data, exp);
    @(negedge core_clk);
  endtask

  // Done must be low one cycle after issue and high exactly in the second.
  task automatic run_op(input dalu_op_e op, input logic acc, input logic [1:0] ma, input logic [1:0] mb,
                        input dalu_src_e src, input dalu_sgn_e sg, input logic rnd, input logic [SHW-1:0] sh);
    p_u.issue(op, acc, ma, mb, src, sg, rnd, sh);
    p_u.idle();
    chk(DW'(alu_done), 24'h00_0000);
    @(negedge core_clk);
    chk(DW'(alu_done), 24'h00_0001);
    chk(DW'(alu_done_acc), DW'(acc));
    @(negedge core_clk);
  endtask

  // Write every input register and A part over X, read it back over Y; extension reads come sign-extended.
  task automatic t_regs();
    dalu_reg_e sel [7] = '{RS_XL, RS_XH, RS_YL, RS_YH, RS_AE, RS_AH, RS_AL};
    logic [DW-1:0] d;
    for (int i = 0; i < 7; i++) begin
      p_u.wr(1'b0, sel[i], 24'h96_1e87 + DW'(i) * 24'h11_1111);
    end
    for (int i = 0; i < 7; i++) begin
      d = 24'h96_1e87 + DW'(i) * 24'h11_1111;
      rd_chk(1'b1, sel[i], sel[i] == RS_AE ? {{16{d[7]}}, d[7:0]} : d);
    end
  endtask

  // Positive overflow, negative overflow and an in-range edge value; X reads the second
  // accumulator and Y the first, so each limiter sees an overflow.
  task automatic t_lim();
    logic [DW-1:0] extension_field [3] = '{24'h00_0001, 24'h00_00fe, 24'h00_00ff};
    logic [DW-1:0] res [3] = '{24'h7f_ffff, 24'h80_0000, 24'h80_0000};
    logic [DW-1:0] hi [3] = '{24'h12_3456, 24'h12_3456, 24'h80_0000};
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 3; i++) begin
        p_u.wr(b[0], b[0] ? RS_AE : RS_BE, extension_field[i]);
        p_u.wr(b[0], b[0] ? RS_AH : RS_BH, hi[i]);
        rd_chk(b[0], b[0] ? RS_AF : RS_BF, res[i]);
        chk(DW'(b[0] ? y_rd_lim : x_rd_lim), DW'(i < 2));
      end
    end
  endtask

  // Both operand orders under each signedness, alternating the destination accumulator.
  task automatic t_mul();
    logic [AW-1:0] ea, eb, e;
    logic [DW-1:0] av, bv;
    dalu_sgn_e sg;
    p_u.wr(1'b0, RS_XL, 24'hc0_0000);
    p_u.wr(1'b1, RS_YH, 24'h40_0000);
    for (int i = 0; i < 6; i++) begin
      av = i[0] ? 24'h40_0000 : 24'hc0_0000;
      bv = i[0] ? 24'hc0_0000 : 24'h40_0000;
      sg = dalu_sgn_e'(i / 2);
      ea = {{32{av[23] & (sg != SG_UU)}}, av};
      eb = {{32{bv[23] & (sg == SG_SS)}}, bv};
      e = (ea * eb) << 1;
      run_op(OP_MPY, i[0], i[0] ? 2'h3 : 2'h0, i[0] ? 2'h0 : 2'h3, SRC_XL, sg, 1'b0, 6'h00);
      rd_chk(1'b0, i[0] ? RS_BF : RS_AF, e[47:24]);
      rd_chk(1'b1, i[0] ? RS_BE : RS_AE, {{16{e[55]}}, e[55:48]});
    end
  endtask

  // Back-to-back issue: the accumulate adds its product to the accumulator result of the multiply just before it.
  task automatic t_pipe();
    p_u.wr(1'b0, RS_XH, 24'h40_0000);
    p_u.issue(OP_MPY, 1'b0, 2'h1, 2'h3, SRC_XL, SG_SS, 1'b0, 6'h00);
    chk(DW'(alu_done), 24'h00_0000);
    p_u.issue(OP_MAC, 1'b0, 2'h1, 2'h3, SRC_XL, SG_SS, 1'b0, 6'h00);
    chk(DW'(alu_done), 24'h00_0001);
    p_u.idle();
    @(negedge core_clk);
    chk(DW'(alu_done), 24'h00_0001);
    @(negedge core_clk);
    chk(DW'(alu_done), 24'h00_0000);
    rd_chk(1'b0, RS_AH, 24'h40_0000);
  endtask

  // A half-way lower field is kept when truncating and carried up when rounding.
  task automatic t_round();
    p_u.wr(1'b0, RS_XL, 24'h00_0000);
    p_u.wr(1'b0, RS_AE, 24'h00_0000);
    p_u.wr(1'b0, RS_AH, 24'h10_0000);
    p_u.wr(1'b1, RS_AL, 24'h80_0000);
    run_op(OP_ADD, 1'b0, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h00);
    rd_chk(1'b0, RS_AL, 24'h80_0000);
    run_op(OP_ADD, 1'b0, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b1, 6'h00);
    rd_chk(1'b0, RS_AH, 24'h10_0001);
    rd_chk(1'b1, RS_AL, 24'h00_0000);
  endtask

  // The right shift crosses the boundary between the upper and lower fields.
  task automatic t_shift();
    p_u.wr(1'b1, RS_BE, 24'h00_0000);
    p_u.wr(1'b1, RS_BH, 24'h01_2345);
    p_u.wr(1'b1, RS_BL, 24'h00_0000);
    run_op(OP_ASL, 1'b1, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h04);
    rd_chk(1'b1, RS_BH, 24'h12_3450);
    run_op(OP_ASR, 1'b1, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h08);
    rd_chk(1'b0, RS_BH, 24'h00_1234);
    rd_chk(1'b1, RS_BL, 24'h50_0000);
  endtask

  // A 16-bit word lands in the upper part of the register and reads back in the low half.
  task automatic t_m16();
    p_u.set16(1'b1);
    p_u.wr(1'b0, RS_XH, 24'h00_abcd);
    rd_chk(1'b1, RS_XH, 24'h00_abcd);
    p_u.set16(1'b0);
    rd_chk(1'b0, RS_XH, 24'hab_cd00);
  endtask

  // Negated product, transfer, pair subtract, logical shift, normalize, clear, pair add.
  task automatic t_ops();
    p_u.wr(1'b0, RS_XH, 24'h40_0000);
    op_neg = 1'b1;
    run_op(OP_MPY, 1'b0, 2'h1, 2'h3, SRC_XL, SG_SS, 1'b0, 6'h00);
    op_neg = 1'b0;
    rd_chk(1'b0, RS_AF, 24'he0_0000);
    run_op(OP_TFR, 1'b1, 2'h0, 2'h0, SRC_ACC, SG_SS, 1'b0, 6'h00);
    run_op(OP_SUB, 1'b1, 2'h0, 2'h0, SRC_XP, SG_SS, 1'b0, 6'h00);
    rd_chk(1'b1, RS_BH, 24'ha0_0000);
    run_op(OP_LSR, 1'b1, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h04);
    rd_chk(1'b0, RS_BE, 24'h00_000f);
    run_op(OP_NORM, 1'b1, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h00);
    rd_chk(1'b1, RS_BE, 24'h00_007f);
    run_op(OP_CLR, 1'b0, 2'h0, 2'h0, SRC_XL, SG_SS, 1'b0, 6'h00);
    run_op(OP_ADD, 1'b0, 2'h0, 2'h0, SRC_YP, SG_SS, 1'b0, 6'h00);
    rd_chk(1'b0, RS_AF, 24'h40_0000);
    rd_chk(1'b1, RS_AL, 24'hb8_40a9);
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    rd_chk(1'b0, RS_AF, 24'h00_0000);
    t_regs();
    t_lim();
    t_mul();
    t_pipe();
    t_round();
    t_shift();
    t_m16();
    t_ops();
    summarize();
  end
endmodule
`default_nettype wire
